// *** core/ascp_port.sv ***
`timescale 1ns/10ps
`include "ascp_map.svh"
module ascp_port
  import ascp_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_sclk,
  input wire logic i_port_select_n,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  output logic o_serial_data_out,
  output logic o_serial_data_out_oe,
  output logic o_dcs_enable,
  output logic [7:0] o_setup,
  output logic [7:0] o_index
);
  ////////////////////////////////////////////////////////////////////////
  // link domain: shifter on the host's serial clock; idle select is high
  ascp_phase_t phase_reg, phase_next;
  logic [15:0] sh_reg, sh_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [7:0] addr_reg, addr_next;
  logic [1:0] len_reg, len_next;
  logic [1:0] done_reg, done_next;
  logic rnw_reg, rnw_next;
  logic [7:0] rd_sh_reg, rd_sh_next;
  ascp_wr_t wr_word_reg, wr_word_next;
  logic wr_tgl_reg, wr_tgl_next;
  logic [7:0] rd_byte;
  logic [7:0] setup_reg;
  logic lsb_first;
  logic [7:0] rx_byte;

  // lsb-first mode flips bit order of data bytes
  function automatic logic [7:0] ascp_flip(input logic [7:0] b, input logic en);
    ascp_flip = en ? {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} : b;
  endfunction : ascp_flip

  // register setup into link domain only used as quasi-static config
  assign lsb_first = setup_reg[`ASCP_BIT_LSB_FIRST];
  assign rx_byte = ascp_flip({sh_reg[6:0], i_sdio}, lsb_first);

  // frame decode: select high returns to instruction phase at once
  always_comb begin
    phase_next = phase_reg;
    sh_next = {sh_reg[14:0], i_sdio};
    cnt_next = cnt_reg + 5'd1;
    addr_next = addr_reg;
    len_next = len_reg;
    done_next = done_reg;
    rnw_next = rnw_reg;
    wr_word_next = wr_word_reg;
    wr_tgl_next = wr_tgl_reg;
    case (phase_reg)
      ASCP_INSTR: begin
        if (cnt_reg == 5'd15) begin
          rnw_next = sh_next[`ASCP_BIT_RNW];
          len_next = {sh_next[`ASCP_BIT_LEN_HI], sh_next[`ASCP_BIT_LEN_LO]};
          addr_next = sh_next[7:0];
          done_next = 2'd0;
          cnt_next = 5'd0;
          phase_next = sh_next[`ASCP_BIT_RNW] ? ASCP_RDATA : ASCP_WDATA;
        end
      end
      ASCP_WDATA, ASCP_RDATA: begin
        if (cnt_reg == 5'd7) begin
          cnt_next = 5'd0;
          if (phase_reg == ASCP_WDATA) begin
            wr_word_next = '{addr: addr_reg, data: rx_byte};
            wr_tgl_next = ~wr_tgl_reg;
          end
          // streaming walks address down, as msb-first ports do
          addr_next = addr_reg - 8'd1;
          done_next = done_reg + 2'd1;
          if (len_reg != 2'b11 && done_reg == len_reg) begin
            phase_next = ASCP_INSTR;
          end
        end
      end
      default: phase_next = ASCP_INSTR;
    endcase
  end

  // readback byte shifts on the falling edge so it is stable at rise
  always_comb begin
    if (phase_reg == ASCP_RDATA && cnt_reg == 5'd0) begin
      rd_sh_next = ascp_flip(rd_byte, lsb_first);
    end else begin
      rd_sh_next = {rd_sh_reg[6:0], 1'b0};
    end
  end

  // select is asynchronous to the serial clock, so it resets the frame
  always_ff @(posedge i_sclk or posedge i_port_select_n) begin
    if (i_port_select_n) begin
      phase_reg <= ASCP_INSTR;
      cnt_reg <= 5'd0;
      sh_reg <= 16'h0000;
      addr_reg <= 8'h00;
      len_reg <= 2'b00;
      done_reg <= 2'd0;
      rnw_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      addr_reg <= addr_next;
      len_reg <= len_next;
      done_reg <= done_next;
      rnw_reg <= rnw_next;
    end
  end

  // write words survive select rising, so held apart from the frame state;
  // chip reset clears the toggle so it matches the core's seen flag
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      wr_word_reg <= '0;
      wr_tgl_reg <= 1'b0;
    end else begin
      wr_word_reg <= wr_word_next;
      wr_tgl_reg <= wr_tgl_next;
    end
  end

  logic rd_out_reg;
  always_ff @(negedge i_sclk or posedge i_port_select_n) begin
    if (i_port_select_n) begin
      rd_sh_reg <= 8'h00;
      rd_out_reg <= 1'b0;
    end else begin
      rd_sh_reg <= rd_sh_next;
      rd_out_reg <= (phase_reg == ASCP_RDATA);
    end
  end

  // drive only in readback, on whichever pin the setup register picks
  logic drive_rd;
  assign drive_rd = rd_out_reg && !i_port_select_n;
  assign o_sdio = rd_sh_reg[7];
  assign o_serial_data_out = rd_sh_reg[7];
  assign o_sdio_oe = drive_rd && !setup_reg[`ASCP_BIT_SDO_ACT];
  assign o_serial_data_out_oe = drive_rd && setup_reg[`ASCP_BIT_SDO_ACT];

  ////////////////////////////////////////////////////////////////////////
  // core domain: toggle crossing and register file
  logic tgl_sync;
  logic tgl_seen_reg, tgl_seen_next;
  ascp_sync u_sync (
    .i_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_d(wr_tgl_reg),
    .o_q(tgl_sync)
  );

  logic [7:0] index_reg, index_next, clock_reg, clock_next;
  logic [7:0] sh_setup_reg, sh_setup_next, sh_index_reg, sh_index_next;
  logic [7:0] sh_clock_reg, sh_clock_next;
  logic [7:0] setup_next;
  logic wr_ev;
  assign wr_ev = tgl_sync != tgl_seen_reg;

  // word is stable for many core cycles after the toggle settles
  always_comb begin
    tgl_seen_next = tgl_sync;
    setup_next = setup_reg;
    index_next = index_reg;
    clock_next = clock_reg;
    sh_setup_next = sh_setup_reg;
    sh_index_next = sh_index_reg;
    sh_clock_next = sh_clock_reg;
    if (wr_ev) begin
      if (wr_word_reg.addr == `ASCP_OFS_SETUP) begin
        // soft reset and undefined bits are not kept; the address-mode
        // pair stays so that writing the default back keeps the default
        sh_setup_next = wr_word_reg.data & 8'hD8;
      end else if (wr_word_reg.addr == `ASCP_OFS_INDEX) begin
        sh_index_next = {4'h0, wr_word_reg.data[3:0]};
      end else if (wr_word_reg.addr == `ASCP_OFS_CLOCK) begin
        sh_clock_next = {7'h00, wr_word_reg.data[`ASCP_BIT_DCS]};
      end else if (wr_word_reg.addr == `ASCP_OFS_COMMIT &&
                   wr_word_reg.data == `ASCP_COMMIT_GO) begin
        setup_next = sh_setup_next;
        index_next = sh_index_next;
        clock_next = sh_clock_next;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tgl_seen_reg <= 1'b0;
      setup_reg <= `ASCP_RST_SETUP;
      index_reg <= `ASCP_RST_INDEX;
      clock_reg <= `ASCP_RST_CLOCK;
      sh_setup_reg <= `ASCP_RST_SETUP;
      sh_index_reg <= `ASCP_RST_INDEX;
      sh_clock_reg <= `ASCP_RST_CLOCK;
    end else if (i_ce) begin
      tgl_seen_reg <= tgl_seen_next;
      setup_reg <= setup_next;
      index_reg <= index_next;
      clock_reg <= clock_next;
      sh_setup_reg <= sh_setup_next;
      sh_index_reg <= sh_index_next;
      sh_clock_reg <= sh_clock_next;
    end
  end

  // readback mux: active values, read from the link clock at frame time
  always_comb begin
    if (addr_reg == `ASCP_OFS_SETUP) begin
      rd_byte = setup_reg;
    end else if (addr_reg == `ASCP_OFS_PARTID) begin
      rd_byte = `ASCP_PART_ID;
    end else if (addr_reg == `ASCP_OFS_GRADE) begin
      rd_byte = `ASCP_GRADE_ID;
    end else if (addr_reg == `ASCP_OFS_INDEX) begin
      rd_byte = index_reg;
    end else if (addr_reg == `ASCP_OFS_CLOCK) begin
      rd_byte = clock_reg;
    end else begin
      rd_byte = 8'h00;
    end
  end

  assign o_dcs_enable = clock_reg[`ASCP_BIT_DCS];
  assign o_setup = setup_reg;
  assign o_index = index_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_reset_defaults: assert property (@(posedge i_core_clk)
    i_rst |=> (o_dcs_enable && o_setup == `ASCP_RST_SETUP))
    else $error("defaults not loaded by reset");
  chk_commit_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && !(wr_ev && wr_word_reg.addr == `ASCP_OFS_COMMIT)) |=> $stable(clock_reg))
    else $error("active register changed without commit");
  chk_commit_apply: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_ce && wr_ev && wr_word_reg.addr == `ASCP_OFS_COMMIT &&
     wr_word_reg.data == `ASCP_COMMIT_GO && wr_word_reg.data == 8'h01)
    |=> o_dcs_enable == $past(sh_clock_reg[0]))
    else $error("commit did not apply stabilizer bit");
  chk_drive_read: assert property (@(posedge i_core_clk)
    (o_sdio_oe || o_serial_data_out_oe) |-> !i_port_select_n)
    else $error("pin driven outside a frame");
  chk_one_pin: assert property (@(posedge i_core_clk)
    !(o_sdio_oe && o_serial_data_out_oe))
    else $error("both data pins driven");
  chk_select_reset: assert property (@(posedge i_core_clk)
    i_port_select_n |-> (phase_reg == ASCP_INSTR && cnt_reg == 5'd0))
    else $error("frame state held with select high");
  chk_index_mask: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_index[7:4] == 4'h0)
    else $error("index upper bits set");
  chk_setup_fields: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_setup[`ASCP_BIT_SOFT_RST] == 1'b0)
    else $error("soft reset bit held");
  cov_commit: cover property (@(posedge i_core_clk)
    wr_ev && wr_word_reg.addr == `ASCP_OFS_COMMIT);
  cov_dcs_off: cover property (@(posedge i_core_clk) $fell(o_dcs_enable));
  cov_read: cover property (@(posedge i_core_clk) $rose(o_sdio_oe));
endmodule : ascp_port

// *** core/ascp_map.svh ***
`ifndef ASCP_MAP_SVH
`define ASCP_MAP_SVH
// register offsets
`define ASCP_OFS_SETUP 8'h00
`define ASCP_OFS_PARTID 8'h01
`define ASCP_OFS_GRADE 8'h02
`define ASCP_OFS_INDEX 8'h05
`define ASCP_OFS_CLOCK 8'h09
`define ASCP_OFS_COMMIT 8'hFF
// group limits
`define ASCP_FUNC_LO 8'h08
`define ASCP_FUNC_HI 8'h53
// reset values
`define ASCP_RST_SETUP 8'h18
`define ASCP_RST_INDEX 8'h0F
`define ASCP_RST_CLOCK 8'h01
`define ASCP_RST_COMMIT 8'h00
// identity values, arbitrary
`define ASCP_PART_ID 8'h5A
`define ASCP_GRADE_ID 8'h05
// field positions
`define ASCP_BIT_SDO_ACT 7
`define ASCP_BIT_LSB_FIRST 6
`define ASCP_BIT_SOFT_RST 5
`define ASCP_BIT_DCS 0
`define ASCP_BIT_COMMIT 0
// commit value
`define ASCP_COMMIT_GO 8'h01
// instruction layout
`define ASCP_INSTR_BITS 16
`define ASCP_BIT_RNW 15
`define ASCP_BIT_LEN_HI 14
`define ASCP_BIT_LEN_LO 13
`endif

// *** core/ascp_pkg.sv ***
package ascp_pkg;
  // one register write crossing from the link domain
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } ascp_wr_t;
  // link-side frame phases
  typedef enum logic [2:0] {
    ASCP_INSTR = 3'b001,
    ASCP_WDATA = 3'b010,
    ASCP_RDATA = 3'b100
  } ascp_phase_t;
endpackage : ascp_pkg

// *** core/ascp_sync.sv ***
`timescale 1ns/10ps
// two-flop level synchroniser
module ascp_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_d,
  output logic o_q
);
  logic meta_reg;
  logic meta_next;
  logic q_reg;
  logic q_next;
  always_comb begin
    meta_next = i_d;
    q_next = meta_reg;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= 1'b0;
      q_reg <= 1'b0;
    end else if (i_ce) begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end
  assign o_q = q_reg;
endmodule : ascp_sync

// *** test/ascp_host_model.sv ***
`timescale 1ns/10ps
// host side of the port; its clock stands still between frames
module ascp_host_model (
  input wire logic i_miso,
  output logic o_sclk,
  output logic o_sel_n,
  output logic o_mosi,
  output logic o_mosi_oe
);
  ////////////////////////////////////////////////////////////
  // idle: deselected, clock low, data line released
  initial {o_sclk, o_sel_n, o_mosi, o_mosi_oe} = 4'b0100;
  ////////////////////////////////////////////////////////////
  // frame: instruction then n bytes; select rises after cut data bits
  task automatic xfer(input logic rnw, input logic [1:0] len, input logic [7:0] a,
      input int n, input logic lsb, input logic [23:0] wd, input int cut,
      output logic [23:0] rd);
    logic [15:0] ins;
    int j;
    ins = {rnw, len, 5'h00, a};
    rd = 24'h0;
    o_sel_n = 1'b0;
    #5;
    for (int k = -16; k < n * 8 && k != cut; k++) begin
      j = k < 0 ? -1 : 16 - 8 * (k / 8) + (lsb ? k % 8 : 7 - k % 8);
      o_mosi = j < 0 ? ins[-k - 1] : wd[j];
      o_mosi_oe = k < 0 || !rnw;
      #3 o_sclk = 1'b1;
      if (j >= 0) rd[j] = i_miso;
      #3 o_sclk = 1'b0;
      // clock parked so the core domain can take each byte
      if (!rnw && k % 8 == 7) #250;
    end
    #3 {o_sel_n, o_mosi_oe} = 2'b10;
    #200;
  endtask : xfer
endmodule : ascp_host_model

// *** test/adc_serial_config_port_tb.sv ***
`timescale 1ns/10ps
`include "ascp_map.svh"
module adc_serial_config_port_tb;
  logic i_core_clk, i_rst, sclk, sel_n, mosi, mosi_oe, sdio_line, miso, e_d, four;
  logic o_sdio, o_sdio_oe, o_serial_data_out, o_serial_data_out_oe, o_dcs_enable;
  logic [7:0] o_setup, o_index, e_s, e_x;
  int n_errors = 0;
  int checked = 0;
  int oe_cnt = 0;
  ////////////////////////////////////////////////////////////
  // released lines fall to their pull-downs
  assign sdio_line = o_sdio_oe ? o_sdio : (mosi_oe ? mosi : 1'b0);
  assign miso = o_serial_data_out_oe ? o_serial_data_out : sdio_line;
  ascp_port DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(1'b1), .i_sclk(sclk),
    .i_port_select_n(sel_n), .i_sdio(sdio_line), .o_sdio(o_sdio), .o_sdio_oe(o_sdio_oe),
    .o_serial_data_out(o_serial_data_out), .o_serial_data_out_oe(o_serial_data_out_oe),
    .o_dcs_enable(o_dcs_enable), .o_setup(o_setup), .o_index(o_index));
  ascp_host_model host (.i_miso(miso), .o_sclk(sclk), .o_sel_n(sel_n), .o_mosi(mosi),
    .o_mosi_oe(mosi_oe));
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  // counts bits the device drives on the shared data pin
  always @(posedge sclk) if (o_sdio_oe === 1'b1) oe_cnt++;
  // a hang ends the run
  initial begin
    #2000000;
    n_errors++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // active outputs after the crossing has had time to land
  task automatic settle();
    repeat (8) @(posedge i_core_clk);
    #1;
    cmp("active", {7'h0, e_d, e_s, e_x}, {7'h0, o_dcs_enable, o_setup, o_index});
  endtask : settle
  // one-byte frame; d is the write data or the expected read data
  task automatic one(input logic rnw, input logic [7:0] a, input logic [7:0] d,
      input logic lsb);
    logic [23:0] rd;
    oe_cnt = 0;
    host.xfer(rnw, 2'b00, a, 1, lsb, {d, 16'h0000}, 99, rd);
    cmp("drive bits", (rnw && !four) ? 24'd8 : 24'd0, oe_cnt[23:0]);
    if (rnw) cmp("read", {d, 16'h0000}, rd);
  endtask : one
  task automatic go(input logic lsb);
    one(1'b0, `ASCP_OFS_COMMIT, `ASCP_COMMIT_GO, lsb);
    settle();
  endtask : go
  ////////////////////////////////////////////////////////////
  initial begin
    logic [23:0] rd;
    logic [7:0] v;
    i_rst = 1'b1;
    four = 1'b0;
    {e_d, e_s, e_x} = {1'b1, `ASCP_RST_SETUP, `ASCP_RST_INDEX};
    void'($urandom(7771));
    repeat (5) @(posedge i_core_clk);
    #1 i_rst = 1'b0;
    // untouched pins: nothing driven, defaults in force
    cmp("pin drive", 24'h0, {22'h0, o_sdio_oe, o_serial_data_out_oe});
    settle();
    one(1'b1, `ASCP_OFS_SETUP, `ASCP_RST_SETUP, 1'b0);
    one(1'b1, `ASCP_OFS_CLOCK, `ASCP_RST_CLOCK, 1'b0);
    one(1'b1, `ASCP_OFS_PARTID, `ASCP_PART_ID, 1'b0);
    one(1'b1, 8'h30, 8'h00, 1'b0);
    // three-byte read walks the address downwards
    host.xfer(1'b1, 2'b10, `ASCP_OFS_GRADE, 3, 1'b0, 24'h0, 99, rd);
    cmp("three", {`ASCP_GRADE_ID, `ASCP_PART_ID, `ASCP_RST_SETUP}, rd);
    // shadow write stays hidden until the right commit value
    one(1'b0, `ASCP_OFS_CLOCK, 8'h00, 1'b0);
    settle();
    one(1'b0, `ASCP_OFS_COMMIT, 8'h02, 1'b0);
    settle();
    e_d = 1'b0;
    go(1'b0);
    // select rising mid-byte drops the partial byte
    host.xfer(1'b0, 2'b00, `ASCP_OFS_CLOCK, 1, 1'b0, 24'hFF0000, 4, rd);
    go(1'b0);
    // random settings through every length code, one commit per sequence
    for (int k = 0; k < 8; k++) begin
      v = 8'($urandom % 2);
      host.xfer(1'b0, 2'(k), `ASCP_OFS_CLOCK, k % 4 == 3 ? 2 : k % 4 + 1, 1'b0,
        {v, 16'h0000}, 99, rd);
      e_d = v[0];
      e_x = 8'($urandom % 16);
      one(1'b0, `ASCP_OFS_INDEX, e_x, 1'b0);
      go(1'b0);
    end
    // lsb-first data, then the separate output pin
    e_s = 8'h58;
    one(1'b0, `ASCP_OFS_SETUP, e_s, 1'b0);
    go(1'b0);
    one(1'b1, `ASCP_OFS_CLOCK, {7'h0, e_d}, 1'b1);
    e_s = 8'h98;
    one(1'b0, `ASCP_OFS_SETUP, e_s, 1'b1);
    go(1'b1);
    four = 1'b1;
    one(1'b1, `ASCP_OFS_PARTID, `ASCP_PART_ID, 1'b0);
    wrap_up();
  end
endmodule : adc_serial_config_port_tb
